// >>> dv/lsi_host_model.sv
// host controller model: emission permit and command pulses
// assumes the bench calls its tasks; pins change just after clk edges
`timescale 1ns/1ps
`default_nettype none
module lsi_host_model (
   input  wire logic clk,
   output logic      permit_in,
   output logic      standby_in,
   output logic      pwm_cmd_in
);
   initial begin
      permit_in  = 1'b0;
      standby_in = 1'b0;
      pwm_cmd_in = 1'b0;
   end
   task automatic enable(input logic on);
      @(posedge clk);
      permit_in <= on;
   endtask
   // one command pulse of n cycles; sel picks pwm over standby
   task automatic pulse(input logic sel, input int n);
      @(posedge clk);
      if (sel) pwm_cmd_in <= 1'b1;
      else standby_in <= 1'b1;
      repeat (n) @(posedge clk);
      pwm_cmd_in <= 1'b0;
      standby_in <= 1'b0;
   endtask
endmodule // lsi_host_model
`default_nettype wire

// >>> dv/lsi_top_chk.sv
// checker for lsi_top: status outputs against pin history
// assumes bind onto lsi_top; single clk domain
`timescale 1ns/1ps
`default_nettype none
module lsi_top_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic permit_in,
   input wire logic over_temp_in,
   input wire logic under_volt_in,
   input wire logic over_volt_in,
   input wire logic dc_sense_in,
   input wire logic pwm_fault_in,
   input wire logic pwm_cmd_in,
   input wire logic rf_standby_out,
   input wire logic rf_pwm_out,
   input wire logic power_indicator,
   input wire logic ready_indicator,
   input wire logic ready_out,
   input wire logic emission_out,
   input wire logic over_temp_out,
   input wire logic supply_fault_output
);
   logic       sup_q;
   logic       pwf_q;
   logic       flt_q;
   logic       pl_q;
   logic [7:0] run_q;
   ////////////////////////////////////////////////////////////////////////////
   // sticky fault history, mirrors latches cleared only by reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sup_q <= 1'b0;
         pwf_q <= 1'b0;
         flt_q <= 1'b0;
         pl_q  <= 1'b0;
         run_q <= 8'h00;
      end else begin
         sup_q <= sup_q | under_volt_in | over_volt_in | dc_sense_in | pwm_fault_in;
         pwf_q <= pwf_q | pwm_fault_in;
         flt_q <= flt_q | sup_q | over_temp_in | under_volt_in | pwm_fault_in;
         pl_q  <= pwm_cmd_in;
         // run length held after fall so a late rise of emission still sees it
         if (pwm_cmd_in) run_q <= !pl_q ? 8'h01 : (run_q == 8'hff ? run_q : run_q + 8'h01);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_steady;
      (permit_in && !flt_q)[*5];
   endsequence
   sequence s_pwm_flt;
      pwf_q[*5];
   endsequence
   pwr_lit_a: assert property (!sup_q |-> power_indicator)
      else $error("power indicator dark without supply fault");
   rdy_on_a: assert property (s_steady |-> ready_out && ready_indicator)
      else $error("ready missing with permit and no fault");
   rdy_drop_a: assert property ($fell(permit_in) && !flt_q |-> ##[1:4] !ready_out && !ready_indicator)
      else $error("ready stayed on after permit loss");
   gate_a: assert property (rf_pwm_out || rf_standby_out |-> ready_out)
      else $error("command passed while not ready");
   lase_len_a: assert property ($rose(emission_out) |-> run_q >= 8'd195)
      else $error("emission after short pulse");
   ot_flag_a: assert property ($rose(over_temp_in) && !sup_q |-> ##[2:4] over_temp_out && !ready_out && !supply_fault_output)
      else $error("overtemp outputs wrong");
   sup_flag_a: assert property ($rose(under_volt_in) && !pwf_q |-> ##[2:4] supply_fault_output && !over_temp_out && !ready_out)
      else $error("supply fault outputs wrong");
   pwm_flt_a: assert property (s_pwm_flt |-> !ready_out && !over_temp_out && !supply_fault_output && !emission_out && !rf_pwm_out)
      else $error("pwm fault outputs wrong");
endmodule // lsi_top_chk
bind lsi_top lsi_top_chk i_chk (.*);
`default_nettype wire

// >>> dv/tb_lsi_top.sv
// testbench for lsi_top: register port tasks and pin scenarios
// assumes lsi_host_model on the host pins; short tick and hold params
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.svh"
module tb_lsi_top;
   import lsi_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ot = 1'b0;
   logic        uv = 1'b0;
   logic        ov = 1'b0;
   logic        dcs = 1'b0;
   logic        pf = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire         permit, stby, pwm, rf_sb, rf_pw, pw_i, rd_i, em_i, rdy, emo, oto, sfo, irq;
   wire  [31:0] reg_rdata;
   int          err_count = 0;
   int          compares = 0;
   int          rt, pt, plow, k;
   always #12.5 clk = ~clk;
   lsi_host_model i_host (.clk(clk), .permit_in(permit), .standby_in(stby), .pwm_cmd_in(pwm));
   lsi_top #(.TICK_CYCLES(10), .HOLD_CYCLES(50)) i_dut (.clk(clk), .resetn(resetn),
      .permit_in(permit), .over_temp_in(ot), .under_volt_in(uv), .over_volt_in(ov),
      .dc_sense_in(dcs), .pwm_fault_in(pf), .standby_in(stby), .pwm_cmd_in(pwm),
      .rf_standby_out(rf_sb), .rf_pwm_out(rf_pw), .power_indicator(pw_i),
      .ready_indicator(rd_i), .emission_indicator(em_i), .ready_out(rdy),
      .emission_out(emo), .over_temp_out(oto), .supply_fault_output(sfo),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      cyc(1);
      chk(reg_rdata, 32'h0);
   endtask
   // status lines {ready, emission, overtemp, supply, emission led}
   task automatic st(input logic [4:0] exp);
      chk({27'h0, rdy, emo, oto, sfo, em_i}, {27'h0, exp});
   endtask
   task automatic watch(input int n);
      logic pr, pp;
      int   run;
      rt = 0;
      pt = 0;
      plow = 0;
      run = 0;
      pr = rd_i;
      pp = pw_i;
      repeat (n) begin
         cyc(1);
         rt += int'(rd_i !== pr);
         pt += int'(pw_i !== pp);
         pr = rd_i;
         pp = pw_i;
         run = pw_i ? 0 : run + 1;
         if (run > plow) plow = run;
      end
   endtask
   task automatic do_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      cyc(1);
   endtask
   task automatic summarize();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      cyc(5);
      st(5'b00000);
      chk(pw_i, 1'b1);
      wr(`LSI_OFS_MASK, 32'h60);
      rd(`LSI_OFS_MASK, 32'h60);
      rd(8'h40, 32'h0);
      wr(`LSI_OFS_EVENT, 32'h7f);
      fork i_host.pulse(1'b0, 20); begin cyc(10); chk(rf_sb, 1'b0); end join
      $display("reset and blocked commands done");
      i_host.enable(1'b1);
      cyc(6);
      st(5'b10000);
      chk(rd_i, 1'b1);
      fork i_host.pulse(1'b0, 20); begin cyc(10); chk(rf_sb, 1'b1); end join
      fork i_host.pulse(1'b1, 100); begin cyc(50); chk(rf_pw, 1'b1); end join
      cyc(10);
      chk(emo, 1'b0);
      k = 0;
      fork i_host.pulse(1'b1, 300);
         while (emo !== 1'b1 && k < 400) begin cyc(1); k++; end
      join
      if (k == 400) begin err_count++; summarize(); end
      chk(em_i, 1'b1);
      $display("commands and emission done");
      i_host.enable(1'b0);
      cyc(6);
      st(5'b00000);
      i_host.enable(1'b1);
      cyc(6);
      st(5'b10000);
      rd(`LSI_OFS_STATE, 32'ha0);
      rd(`LSI_OFS_EVENT, 32'h60);
      chk(irq, 1'b1);
      wr(`LSI_OFS_EVENT, 32'h60);
      cyc(2);
      chk(irq, 1'b0);
      $display("permit loss and interrupt done");
      ot <= 1'b1;
      cyc(6);
      ot <= 1'b0;
      st(5'b00100);
      watch(4000);
      chk(rt != 0 && pt == 0, 1'b1);
      st(5'b00100);
      rd(`LSI_OFS_EVENT, 32'h01);
      fork i_host.pulse(1'b1, 20); begin cyc(10); chk(rf_pw, 1'b0); end join
      $display("overtemp done");
      for (int i = 0; i < 3; i++) begin
         do_reset();
         {uv, ov, dcs} <= 3'b100 >> i;
         cyc(6);
         st(5'b00010);
         chk(rd_i, 1'b0);
         watch(16000);
         chk(pt >= 2 && plow >= 5000, 1'b1);
         {uv, ov, dcs} <= 3'b000;
      end
      $display("supply faults done");
      do_reset();
      pf <= 1'b1;
      cyc(6);
      st(5'b00000);
      watch(4000);
      chk(rt != 0 && pt != 0, 1'b1);
      $display("pwm fault done");
      summarize();
   end
endmodule // tb_lsi_top
`default_nettype wire

// >>> rtl/lsi_blink.sv
// blink code sequencer for one indicator
// assumes tick is a one-cycle pulse every millisecond
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.svh"
module lsi_blink
   import lsi_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       tick,
   input  wire logic       active,
   input  wire logic [1:0] code,
   output logic            led_q
);

   lsi_blink_st_t state_q;
   lsi_blink_st_t state_d;
   logic [9:0]    cnt_q;
   logic [1:0]    num_q;
   wire           on_end    = tick && (cnt_q == `LSI_ON_MS - 10'd1);
   wire           off_end   = tick && (cnt_q == `LSI_OFF_MS - 10'd1);
   wire           pause_end = tick && (cnt_q == `LSI_PAUSE_MS - 10'd1);
   wire           last_blk  = (num_q == code - 2'd1);

   always_comb begin
      state_d = state_q;
      case (state_q)
         LSI_BL_IDLE:  if (active) state_d = LSI_BL_ON;
         LSI_BL_ON:    if (on_end) state_d = LSI_BL_OFF;
         LSI_BL_OFF: begin
            if (off_end) begin
               // code zero flashes without the pause
               if (code != `LSI_CODE_FLASH && last_blk) state_d = LSI_BL_PAUSE;
               else state_d = LSI_BL_ON;
            end
         end
         LSI_BL_PAUSE: if (pause_end) state_d = LSI_BL_ON;
         default:      state_d = LSI_BL_IDLE;
      endcase
      if (!active) state_d = LSI_BL_IDLE;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= LSI_BL_IDLE;
         cnt_q   <= 10'h000;
         num_q   <= 2'h0;
         led_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         led_q   <= (state_d == LSI_BL_ON);
         if (state_d != state_q) cnt_q <= 10'h000;
         else if (tick) cnt_q <= cnt_q + 10'd1;
         if (state_d == LSI_BL_IDLE || state_d == LSI_BL_PAUSE) num_q <= 2'h0;
         else if (state_q == LSI_BL_OFF && state_d == LSI_BL_ON) num_q <= num_q + 2'd1;
      end
   end

endmodule // lsi_blink
`default_nettype wire

// >>> rtl/lsi_pkg.sv
// types shared by the status indicator logic
// assumes lsi_regs.svh for all numeric constants
package lsi_pkg;

   typedef struct packed {
      logic permit;
      logic over_temp;
      logic under_volt;
      logic over_volt;
      logic dc_sense;
      logic pwm_fault;
      logic standby;
      logic pwm_cmd;
   } lsi_pins_t;

   typedef struct packed {
      logic over_temp;
      logic under_volt;
      logic over_volt;
      logic dc_sense;
      logic pwm_fault;
   } lsi_faults_t;

   typedef enum logic [1:0] {
      LSI_BL_IDLE  = 2'b00,
      LSI_BL_ON    = 2'b01,
      LSI_BL_OFF   = 2'b11,
      LSI_BL_PAUSE = 2'b10
   } lsi_blink_st_t;

endpackage

// >>> rtl/lsi_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz core clock and a byte-addressed 32-bit register port
`ifndef LSI_REGS_SVH
`define LSI_REGS_SVH

`define LSI_CLK_PERIOD_NS 25

// register byte offsets
`define LSI_OFS_STATE     8'h00
`define LSI_OFS_EVENT     8'h04
`define LSI_OFS_MASK      8'h08

// event and state bit positions
`define LSI_EV_OVER_TEMP  0
`define LSI_EV_UNDER_VOLT 1
`define LSI_EV_OVER_VOLT  2
`define LSI_EV_DC_SENSE   3
`define LSI_EV_PWM_FAULT  4
`define LSI_EV_PERMIT_OFF 5
`define LSI_EV_PERMIT_ON  6
`define LSI_EV_W          7
`define LSI_ST_PERMIT     5
`define LSI_ST_EMISSION   6
`define LSI_ST_READY      7
`define LSI_ST_W          8

`define LSI_MASK_RST      7'h00

// timing
`define LSI_TICK_NS       1000000
`define LSI_LASE_MIN_NS   5000
`define LSI_LASE_HOLD_NS  1000000
`define LSI_TICK_CYC      ((`LSI_TICK_NS) / (`LSI_CLK_PERIOD_NS))
`define LSI_LASE_MIN_CYC  (((`LSI_LASE_MIN_NS) + (`LSI_CLK_PERIOD_NS) - 1) / (`LSI_CLK_PERIOD_NS))
`define LSI_LASE_HOLD_CYC ((`LSI_LASE_HOLD_NS) / (`LSI_CLK_PERIOD_NS))

// blink timing in millisecond ticks
`define LSI_ON_MS         10'd150
`define LSI_OFF_MS        10'd150
`define LSI_PAUSE_MS      10'd500

// supply fault blink codes, zero means continuous flashing
`define LSI_CODE_FLASH    2'd0
`define LSI_CODE_UV       2'd1
`define LSI_CODE_OV       2'd2
`define LSI_CODE_DCS      2'd3

`endif

// >>> rtl/lsi_sync.sv
// two-flop synchroniser for the asynchronous pin inputs
// assumes pins are quasi-static levels relative to clk
`timescale 1ns/1ps
`default_nettype none
module lsi_sync
   import lsi_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire lsi_pins_t pins_in,
   output lsi_pins_t      pins_s
);

   lsi_pins_t meta_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         pins_s <= '0;
      end else begin
         meta_q <= pins_in;
         pins_s <= meta_q;
      end
   end

endmodule // lsi_sync
`default_nettype wire

// >>> rtl/lsi_top.sv
// laser status and fault indication logic: indicators, host status lines,
// command pass-through gate, fault latches, register port and interrupt
// assumes all pin inputs are asynchronous levels and resetn is power-on reset
//
// Functional notes
// - power indicator green from power-up, regardless of permit or commands
// - ready indicator steady yellow only while permit asserted and no fault
// - standby and pwm commands reach rf driver only after permit asserted
// - emission indicator red only for pwm pulses long enough to lase
// - normal: ready high, faults low, emission output follows lasing pwm
// - permit missing: ready and emission off, power green, all outputs low
// - over-temperature: ready flashes, overtemp high, ready and emission low
// - supply fault: power blinks, supply fault high, ready off, others low
// - pwm sense fault: ready and power flash, emission off, outputs low
// - supply fault blink code repeats after half-second pause; fault stays latched
// - undervoltage shown as one power blink repeated every 800 ms, after the half-second pause
// - permit loss not latched; restoring it re-enables ready three clk edges later (two synchroniser flops, then the output register)
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.svh"
module lsi_top
   import lsi_pkg::*;
#(
   parameter int TICK_CYCLES = `LSI_TICK_CYC,
   parameter int HOLD_CYCLES = `LSI_LASE_HOLD_CYC
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   // pins from the host connector and the internal sensors
   input  wire logic        permit_in,
   input  wire logic        over_temp_in,
   input  wire logic        under_volt_in,
   input  wire logic        over_volt_in,
   input  wire logic        dc_sense_in,
   input  wire logic        pwm_fault_in,
   input  wire logic        standby_in,
   input  wire logic        pwm_cmd_in,
   // commands to the rf driver
   output logic             rf_standby_out,
   output logic             rf_pwm_out,
   // front-panel indicators
   output logic             power_indicator,
   output logic             ready_indicator,
   output logic             emission_indicator,
   // host status lines
   output logic             ready_out,
   output logic             emission_out,
   output logic             over_temp_out,
   output logic             supply_fault_output,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // hardware set beats a software clear in the same cycle
   function automatic logic [`LSI_EV_W-1:0] sticky(
      input logic [`LSI_EV_W-1:0] cur,
      input logic [`LSI_EV_W-1:0] set,
      input logic [`LSI_EV_W-1:0] clr
   );
      sticky = (cur & ~clr) | set;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   lsi_pins_t pins_raw;
   lsi_pins_t pins_s;

   assign pins_raw = '{permit:     permit_in,
                       over_temp:  over_temp_in,
                       under_volt: under_volt_in,
                       over_volt:  over_volt_in,
                       dc_sense:   dc_sense_in,
                       pwm_fault:  pwm_fault_in,
                       standby:    standby_in,
                       pwm_cmd:    pwm_cmd_in};

   lsi_sync u_sync (
      .clk     (clk),
      .resetn  (resetn),
      .pins_in (pins_raw),
      .pins_s  (pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // fault latches

   lsi_faults_t fault_q;
   lsi_faults_t fault_raw;

   assign fault_raw = '{over_temp:  pins_s.over_temp,
                        under_volt: pins_s.under_volt,
                        over_volt:  pins_s.over_volt,
                        dc_sense:   pins_s.dc_sense,
                        pwm_fault:  pins_s.pwm_fault};

   // no software clear path: a fault stays until power is cycled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) fault_q <= '0;
      else fault_q <= fault_q | fault_raw;
   end

   wire supply_flt = fault_q.under_volt | fault_q.over_volt | fault_q.dc_sense;
   wire pwm_flt    = fault_q.pwm_fault;
   wire ot_flt     = fault_q.over_temp;
   wire any_flt    = supply_flt | pwm_flt | ot_flt;

   // permit is taken live, never latched
   wire gate_open  = pins_s.permit & ~any_flt;

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick for the blink sequencers

   logic [15:0] tick_cnt_q;
   wire         tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) tick_cnt_q <= 16'h0000;
      else if (tick) tick_cnt_q <= 16'h0000;
      else tick_cnt_q <= tick_cnt_q + 16'd1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // lasing pulse detection
   // standby pulses are not timed at all and never qualify, whatever their width;
   // the hold keeps the indicator steady between command pulses

   logic [7:0]  width_q;
   logic [15:0] hold_q;
   wire         width_met = (width_q == 8'(`LSI_LASE_MIN_CYC - 1)) & pins_s.pwm_cmd;
   wire         lasing    = (hold_q != 16'h0000);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         width_q <= 8'h00;
         hold_q  <= 16'h0000;
      end else begin
         if (!pins_s.pwm_cmd || !gate_open) width_q <= 8'h00;
         else if (!width_met) width_q <= width_q + 8'd1;
         if (!gate_open) hold_q <= 16'h0000;
         else if (width_met) hold_q <= 16'(HOLD_CYCLES);
         else if (lasing) hold_q <= hold_q - 16'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // blink sequencers

   logic [1:0] supply_code;
   logic       ready_blink;
   logic       power_blink;

   // undervoltage wins when several supply faults latch together
   assign supply_code = fault_q.under_volt ? `LSI_CODE_UV :
                        fault_q.over_volt  ? `LSI_CODE_OV :
                        `LSI_CODE_DCS;

   wire       ready_flash = pwm_flt | (ot_flt & ~supply_flt);
   wire       power_act   = pwm_flt | supply_flt;
   wire [1:0] power_code  = pwm_flt ? `LSI_CODE_FLASH : supply_code;

   lsi_blink u_ready_blink (
      .clk    (clk),
      .resetn (resetn),
      .tick   (tick),
      .active (ready_flash),
      .code   (`LSI_CODE_FLASH),
      .led_q  (ready_blink)
   );

   lsi_blink u_power_blink (
      .clk    (clk),
      .resetn (resetn),
      .tick   (tick),
      .active (power_act),
      .code   (power_code),
      .led_q  (power_blink)
   );

   ////////////////////////////////////////////////////////////////////////////
   // indicator and status selection

   wire power_d    = power_act ? power_blink : 1'b1;
   wire ready_led  = ready_flash ? ready_blink : gate_open;
   wire emit_d     = gate_open & lasing;
   wire ot_d       = ot_flt & ~supply_flt & ~pwm_flt;
   wire supply_d   = supply_flt & ~pwm_flt;

   // registered so every status line changes on the same edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_indicator     <= 1'b1;
         ready_indicator     <= 1'b0;
         emission_indicator  <= 1'b0;
         ready_out           <= 1'b0;
         emission_out        <= 1'b0;
         over_temp_out       <= 1'b0;
         supply_fault_output <= 1'b0;
         rf_standby_out      <= 1'b0;
         rf_pwm_out          <= 1'b0;
      end else begin
         power_indicator     <= power_d;
         ready_indicator     <= ready_led;
         emission_indicator  <= emit_d;
         ready_out           <= gate_open;
         emission_out        <= emit_d;
         over_temp_out       <= ot_d;
         supply_fault_output <= supply_d;
         rf_standby_out      <= pins_s.standby & gate_open;
         rf_pwm_out          <= pins_s.pwm_cmd & gate_open;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events and interrupt

   logic                  permit_q;
   lsi_faults_t           fault_prev_q;
   logic [`LSI_EV_W-1:0]  event_q;
   logic [`LSI_EV_W-1:0]  mask_q;
   logic [`LSI_EV_W-1:0]  ev_set;
   logic [`LSI_EV_W-1:0]  ev_clr;
   lsi_faults_t           fault_new;

   assign fault_new = fault_q & ~fault_prev_q;

   assign ev_set = {pins_s.permit & ~permit_q,
                    ~pins_s.permit & permit_q,
                    fault_new.pwm_fault,
                    fault_new.dc_sense,
                    fault_new.over_volt,
                    fault_new.under_volt,
                    fault_new.over_temp};

   wire wr_event = reg_wr & (reg_addr == `LSI_OFS_EVENT);
   wire wr_mask  = reg_wr & (reg_addr == `LSI_OFS_MASK);

   assign ev_clr = wr_event ? reg_wdata[`LSI_EV_W-1:0] : '0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         permit_q     <= 1'b0;
         fault_prev_q <= '0;
         event_q      <= '0;
         mask_q       <= `LSI_MASK_RST;
         irq          <= 1'b0;
      end else begin
         permit_q     <= pins_s.permit;
         fault_prev_q <= fault_q;
         event_q      <= sticky(event_q, ev_set, ev_clr);
         if (wr_mask) mask_q <= reg_wdata[`LSI_EV_W-1:0];
         irq          <= |(sticky(event_q, ev_set, ev_clr) & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port

   logic [`LSI_ST_W-1:0] live_state;
   logic [31:0]          rd_mux;

   assign live_state = {ready_out, emission_out, pins_s.permit,
                        fault_q.pwm_fault, fault_q.dc_sense, fault_q.over_volt,
                        fault_q.under_volt, fault_q.over_temp};

   // unmapped offsets read as zero
   assign rd_mux = (reg_addr == `LSI_OFS_STATE) ? {24'h000000, live_state} :
                   (reg_addr == `LSI_OFS_EVENT) ? {25'h0000000, event_q} :
                   (reg_addr == `LSI_OFS_MASK)  ? {25'h0000000, mask_q} :
                   32'h00000000;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) reg_rdata <= 32'h00000000;
      else if (reg_rd) reg_rdata <= rd_mux;
      else reg_rdata <= 32'h00000000;
   end

endmodule // lsi_top
`default_nettype wire
